// ### rtl/ssp_pkg.sv
// Purpose: Shared constants for the slave serial port and its master end
// Assumes: 40 MHz core clock on both ends
// Notes: Master register map lives here too
package ssp_pkg;
  localparam int CHAR_W = 8;
  localparam int BLEN_W = 16;
  localparam int CNT_W = 3;
  localparam int SYNC_N = 3;
  localparam logic [CNT_W-1:0] LAST_BIT = 3'h7;
  localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
  localparam logic [BLEN_W-1:0] BITS_ONE = 16'h0001;
  localparam logic [CHAR_W-1:0] BYTE_ZERO = 8'h00;
  // Serial clock limit and the half period the master must keep
  localparam int CORE_KHZ = 40000;
  localparam int SCK_MAX_KHZ = 1600;
  localparam int HALF_CYC = (CORE_KHZ + 2 * SCK_MAX_KHZ - 1) / (2 * SCK_MAX_KHZ);
  localparam int DIV_W = 5;
  localparam logic [DIV_W-1:0] HALF_LAST = DIV_W'(HALF_CYC - 1);
  // Master APB register map
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_NBITS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_TXD = 8'h08;
  localparam logic [ADDR_W-1:0] REG_RXD = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_STAT = 8'h10;
  localparam int CTRL_START = 0;
  localparam int CTRL_POL = 1;
  localparam int CTRL_PHA = 2;
  localparam int CTRL_FRM = 3;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int NB_W = 4;
  localparam logic [NB_W-1:0] NB_RST = 4'h8;
  localparam logic [NB_W-1:0] NB_ONE = 4'h1;
  // Master sequencer states, gray along the path
  typedef enum logic [1:0] {
    SSP_IDLE = 2'b00,
    SSP_SETUP = 2'b01,
    SSP_LEAD = 2'b11,
    SSP_TRAIL = 2'b10
  } ssp_state_t;
endpackage

// ### rtl/ssp_if.sv
// Purpose: Serial link between slave port and external master
// Assumes: Serial output has no pull, released line shows the inverse level
// Notes: Frame input is driven by the master
`timescale 1ns/1ps
interface ssp_if;
  logic sck;
  logic si;
  logic frame_control_in;
  logic so;
  logic so_oe;
  wire so_line;
  // Released output shows the inverse so stale data is never taken as valid
  assign so_line = so_oe ? so : ~so;
  modport dev (input sck, input si, input frame_control_in, output so, output so_oe);
  modport mst (output sck, output si, output frame_control_in, input so_line);
endinterface

// ### rtl/ssp_dev.sv
// Purpose: Slave-only synchronous serial port, device end
// Assumes: Link pins are asynchronous to core_clk and pass a 3-stage filter
// Notes: Mode settings are plain inputs held by the owning register block
`timescale 1ns/1ps
module ssp_dev
  import ssp_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  ssp_if.dev link,
  input wire logic port_clock_gate_bit,
  input wire logic clock_polarity_sel,
  input wire logic clock_phase_sel,
  input wire logic frame_input_enable,
  input wire logic frame_function_sel,
  input wire logic bit_order_sel,
  input wire logic tx_enable,
  input wire logic rx_enable,
  input wire logic burst_mode,
  input wire logic [ssp_pkg::BLEN_W-1:0] burst_len,
  input wire logic [ssp_pkg::CHAR_W-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic tx_underrun,
  output logic [ssp_pkg::CHAR_W-1:0] rx_data,
  output logic rx_valid,
  output logic burst_done
);

  // Shift a byte one place toward its far end
  function automatic logic [CHAR_W-1:0] shift_out(logic [CHAR_W-1:0] sr, logic lsb);
    shift_out = lsb ? {1'b0, sr[CHAR_W-1:1]} : {sr[CHAR_W-2:0], 1'b0};
  endfunction

  // Insert a received bit at the proper end
  function automatic logic [CHAR_W-1:0] shift_in(logic [CHAR_W-1:0] sr, logic b, logic lsb);
    shift_in = lsb ? {b, sr[CHAR_W-1:1]} : {sr[CHAR_W-2:0], b};
  endfunction

  logic [SYNC_N-1:0] sck_sy_ff, si_sy_ff, frm_sy_ff;
  logic sck_ff, si_ff, frm_ff, sck_prev_ff;
  logic rise, fall, lead, trail, sample_e, shift_e;
  logic run, dir_tx, dir_rx, frame_dir, frame_gate, halted, step_s, step_d;
  logic [BLEN_W-1:0] bits_ff;
  logic [CHAR_W-1:0] rx_sr_ff, tx_sr_ff, hold_ff;
  logic [CNT_W-1:0] rx_cnt_ff, tx_cnt_ff;
  logic hold_full_ff, loaded_ff, primed_ff, tx_ready_ff, tx_underrun_ff;
  logic [CHAR_W-1:0] rx_data_ff;
  logic rx_valid_ff, burst_done_ff, so_ff, so_oe_ff, rx_last;

  // Three-stage synchronisers; value moves when stages two and three agree
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
    begin
      sck_sy_ff <= '0;
      si_sy_ff <= '0;
      frm_sy_ff <= '0;
    end
    else
    begin
      sck_sy_ff <= {sck_sy_ff[SYNC_N-2:0], link.sck};
      si_sy_ff <= {si_sy_ff[SYNC_N-2:0], link.si};
      frm_sy_ff <= {frm_sy_ff[SYNC_N-2:0], link.frame_control_in};
    end

  // Filtered pin levels and previous clock level
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
    begin
      sck_ff <= 1'b0;
      si_ff <= 1'b0;
      frm_ff <= 1'b0;
      sck_prev_ff <= 1'b0;
    end
    else
    begin
      if (sck_sy_ff[1] == sck_sy_ff[2]) sck_ff <= sck_sy_ff[2];
      if (si_sy_ff[1] == si_sy_ff[2]) si_ff <= si_sy_ff[2];
      if (frm_sy_ff[1] == frm_sy_ff[2]) frm_ff <= frm_sy_ff[2];
      sck_prev_ff <= sck_ff;
    end

  // Edge roles from polarity and phase
  always_comb
  begin
    rise = sck_ff & ~sck_prev_ff;
    fall = ~sck_ff & sck_prev_ff;
    lead = clock_polarity_sel ? fall : rise;
    trail = clock_polarity_sel ? rise : fall;
    sample_e = clock_phase_sel ? trail : lead;
    shift_e = clock_phase_sel ? lead : trail;
  end

  // Frame handling, clock gate and burst halt
  always_comb
  begin
    run = port_clock_gate_bit;
    frame_dir = frame_input_enable & ~frame_function_sel;
    frame_gate = frame_input_enable & frame_function_sel & frm_ff;
    dir_tx = ~frame_dir | frm_ff;
    dir_rx = ~frame_dir | ~frm_ff;
    halted = burst_mode & (bits_ff == burst_len);
    step_s = run & ~halted & sample_e;
    step_d = run & ~halted & shift_e;
    rx_last = burst_mode & (bits_ff + BITS_ONE == burst_len);
  end

  // Burst bit counter, restarted by dropping both enables
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
    begin
      bits_ff <= '0;
      burst_done_ff <= 1'b0;
    end
    else
    begin
      if (!run || (!tx_enable && !rx_enable)) bits_ff <= '0;
      else if (step_s) bits_ff <= bits_ff + BITS_ONE;
      burst_done_ff <= run & halted & (tx_enable | rx_enable);
    end

  // Receive shifter, byte pushed when full or burst ends
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
    begin
      rx_sr_ff <= '0;
      rx_cnt_ff <= '0;
      rx_data_ff <= '0;
      rx_valid_ff <= 1'b0;
    end
    else
    begin
      rx_valid_ff <= 1'b0;
      if (!run || !rx_enable) rx_cnt_ff <= '0;
      else if (step_s && dir_rx)
      begin
        rx_sr_ff <= shift_in(rx_sr_ff, si_ff, bit_order_sel);
        rx_cnt_ff <= rx_cnt_ff + CNT_ONE;
        if (rx_cnt_ff == LAST_BIT || rx_last)
        begin
          rx_data_ff <= shift_in(rx_sr_ff, si_ff, bit_order_sel);
          rx_valid_ff <= 1'b1;
          rx_cnt_ff <= '0;
        end
      end
    end

  // One-byte holding stage for the transmit side
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
    begin
      hold_ff <= '0;
      hold_full_ff <= 1'b0;
      tx_ready_ff <= 1'b0;
    end
    else
    begin
      if (tx_valid && tx_ready_ff)
      begin
        hold_ff <= tx_data;
        hold_full_ff <= 1'b1;
      end
      else if (run && tx_enable && (!loaded_ff || (step_d && primed_ff
               && tx_cnt_ff == LAST_BIT)))
        hold_full_ff <= 1'b0;
      tx_ready_ff <= ~hold_full_ff & ~(tx_valid & tx_ready_ff);
    end

  // Transmit shifter; phase 1 uses its first shift edge to present bit one
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
    begin
      tx_sr_ff <= '0;
      tx_cnt_ff <= '0;
      loaded_ff <= 1'b0;
      primed_ff <= 1'b0;
      tx_underrun_ff <= 1'b0;
    end
    else
    begin
      tx_underrun_ff <= 1'b0;
      if (!run || !tx_enable)
      begin
        loaded_ff <= 1'b0;
        primed_ff <= 1'b0;
        tx_cnt_ff <= '0;
      end
      else if (!loaded_ff)
      begin
        if (hold_full_ff)
        begin
          tx_sr_ff <= hold_ff;
          loaded_ff <= 1'b1;
          primed_ff <= ~clock_phase_sel;
        end
      end
      else if (step_d && dir_tx)
      begin
        if (!primed_ff) primed_ff <= 1'b1;
        else if (tx_cnt_ff == LAST_BIT)
        begin
          tx_cnt_ff <= '0;
          tx_sr_ff <= hold_full_ff ? hold_ff : BYTE_ZERO;
          tx_underrun_ff <= ~hold_full_ff;
        end
        else
        begin
          tx_sr_ff <= shift_out(tx_sr_ff, bit_order_sel);
          tx_cnt_ff <= tx_cnt_ff + CNT_ONE;
        end
      end
    end

  // Serial output level and enable
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
    begin
      so_ff <= 1'b0;
      so_oe_ff <= 1'b0;
    end
    else
    begin
      so_ff <= bit_order_sel ? tx_sr_ff[0] : tx_sr_ff[CHAR_W-1];
      so_oe_ff <= run & tx_enable & dir_tx & ~frame_gate;
    end

  assign link.so = so_ff;
  assign link.so_oe = so_oe_ff;
  assign tx_ready = tx_ready_ff;
  assign tx_underrun = tx_underrun_ff;
  assign rx_data = rx_data_ff;
  assign rx_valid = rx_valid_ff;
  assign burst_done = burst_done_ff;

endmodule

// ### rtl/ssp_mst.sv
// Purpose: External serial master with an APB register port
// Assumes: Serial clock made here by dividing core_clk
// Notes: Sends 1 to 16 bits per start (a count of 0 gives 16), bit 7 of the data register first
`timescale 1ns/1ps
module ssp_mst
  import ssp_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ssp_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  ssp_if.mst link
);

  ssp_state_t state_ff;
  logic [DIV_W-1:0] div_ff;
  logic [NB_W-1:0] nbits_ff, left_ff;
  logic [CHAR_W-1:0] txd_ff, rxd_ff, tx_sr_ff;
  logic pol_ff, pha_ff, frm_ff, done_ff, start, wr, rd, half_end;
  logic sck_ff, si_ff, pready_ff;
  logic [31:0] prdata_ff;
  logic [SYNC_N-1:0] so_sy_ff;
  logic so_ff;

  // Access phase completes two cycles after penable rises; pready rises after one
  always_comb
  begin
    wr = psel & penable & pready_ff & pwrite;
    rd = psel & penable & ~pready_ff & ~pwrite;
    start = wr & (paddr == REG_CTRL) & pwdata[CTRL_START] & (state_ff == SSP_IDLE);
    half_end = (div_ff == HALF_LAST);
  end

  // APB handshake and read data
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
    begin
      pready_ff <= 1'b0;
      prdata_ff <= '0;
    end
    else
    begin
      pready_ff <= psel & penable & ~pready_ff;
      if (rd)
      begin
        unique case (paddr)
          REG_CTRL: prdata_ff <= {28'h0, frm_ff, pha_ff, pol_ff, 1'b0};
          REG_NBITS: prdata_ff <= {28'h0, nbits_ff};
          REG_TXD: prdata_ff <= {24'h0, txd_ff};
          REG_RXD: prdata_ff <= {24'h0, rxd_ff};
          REG_STAT: prdata_ff <= {30'h0, done_ff, state_ff != SSP_IDLE};
          default: prdata_ff <= '0;
        endcase
      end
    end

  // Software settings
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
    begin
      pol_ff <= 1'b0;
      pha_ff <= 1'b0;
      frm_ff <= 1'b0;
      nbits_ff <= NB_RST;
      txd_ff <= '0;
    end
    else if (wr)
    begin
      if (paddr == REG_CTRL)
      begin
        pol_ff <= pwdata[CTRL_POL];
        pha_ff <= pwdata[CTRL_PHA];
        frm_ff <= pwdata[CTRL_FRM];
      end
      if (paddr == REG_NBITS) nbits_ff <= pwdata[NB_W-1:0];
      if (paddr == REG_TXD) txd_ff <= pwdata[CHAR_W-1:0];
    end

  // Serial output synchroniser, three stages
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
    begin
      so_sy_ff <= '0;
      so_ff <= 1'b0;
    end
    else
    begin
      so_sy_ff <= {so_sy_ff[SYNC_N-2:0], link.so_line};
      if (so_sy_ff[1] == so_sy_ff[2]) so_ff <= so_sy_ff[2];
    end

  // Clock generator and shifter: each state after SSP_IDLE lasts one half period
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
    begin
      state_ff <= SSP_IDLE;
      div_ff <= '0;
      sck_ff <= 1'b0;
      si_ff <= 1'b0;
      tx_sr_ff <= '0;
      rxd_ff <= '0;
      left_ff <= '0;
      done_ff <= 1'b0;
    end
    else
    begin
      if (wr && paddr == REG_STAT && pwdata[STAT_DONE]) done_ff <= 1'b0;
      div_ff <= (state_ff == SSP_IDLE || half_end) ? '0 : div_ff + 5'h01;
      unique case (state_ff)
        SSP_IDLE:
        begin
          sck_ff <= pol_ff;
          if (start)
          begin
            state_ff <= SSP_SETUP;
            left_ff <= nbits_ff;
            tx_sr_ff <= {txd_ff[CHAR_W-2:0], 1'b0};
            if (!pha_ff) si_ff <= txd_ff[CHAR_W-1];
            else tx_sr_ff <= txd_ff;
          end
        end
        SSP_SETUP, SSP_TRAIL:
          if (half_end)
          begin
            if (state_ff == SSP_TRAIL && left_ff == '0)
            begin
              state_ff <= SSP_IDLE;
              done_ff <= 1'b1;
            end
            else
            begin
              state_ff <= SSP_LEAD;
              sck_ff <= ~pol_ff;
              if (pha_ff)
              begin
                si_ff <= tx_sr_ff[CHAR_W-1];
                tx_sr_ff <= {tx_sr_ff[CHAR_W-2:0], 1'b0};
              end
              else rxd_ff <= {rxd_ff[CHAR_W-2:0], so_ff};
            end
          end
        SSP_LEAD:
          if (half_end)
          begin
            state_ff <= SSP_TRAIL;
            sck_ff <= pol_ff;
            left_ff <= left_ff - NB_ONE;
            if (pha_ff) rxd_ff <= {rxd_ff[CHAR_W-2:0], so_ff};
            else
            begin
              si_ff <= tx_sr_ff[CHAR_W-1];
              tx_sr_ff <= {tx_sr_ff[CHAR_W-2:0], 1'b0};
            end
          end
      endcase
    end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = 1'b0;
  assign link.sck = sck_ff;
  assign link.si = si_ff;
  assign link.frame_control_in = frm_ff;

endmodule

// ### dv/ssp_assertions.sv
// Purpose: Wire-level checks on the serial link between both ends
// Assumes: Both ends run on core_clk
// Notes: Gap counter measures cycles since the serial clock last moved
`timescale 1ns/1ps
module ssp_assertions
  import ssp_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic sck,
  input wire logic si,
  input wire logic frame_control_in,
  input wire logic so,
  input wire logic so_oe,
  input wire logic frame_input_enable,
  input wire logic frame_function_sel
);
  logic sck_ff;
  logic [7:0] gap_ff;
  logic edge_seen;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  // Serial clock edge seen this cycle
  assign edge_seen = sck != sck_ff;
  // Cycles since the last serial clock edge, saturating
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sck_ff <= 1'b0;
      gap_ff <= 8'hFF;
    end
    else
    begin
      sck_ff <= sck;
      gap_ff <= edge_seen ? 8'h00 : ((gap_ff == 8'hFF) ? gap_ff : gap_ff + 8'h01);
    end
  end
  chk_sck_half_gap: assert property (edge_seen |-> gap_ff >= HALF_CYC - 1)
    else $error("serial clock half period too short");
  chk_so_edge_delay: assert property ($changed(so) && so_oe && gap_ff < 8'h0C |-> gap_ff inside {[3:5]})
    else $error("serial output moved off its shift slot");
  chk_so_quiet_edge: assert property ($changed(sck) |=> $stable(so) [*3])
    else $error("serial output moved too soon after clock edge");
  chk_so_hold_sample: assert property ($changed(sck) && so_oe |-> $stable(so))
    else $error("serial output changed at a sampling edge");
  chk_si_settle: assert property ($changed(si) |=> $stable(si) [*8])
    else $error("serial input not held for the bit time");
  chk_frame_hiz: assert property ((frame_input_enable && frame_function_sel && frame_control_in) [*6] |-> !so_oe)
    else $error("serial output driven while frame high");
  chk_dir_rx_only: assert property ((frame_input_enable && !frame_function_sel && !frame_control_in) [*6] |-> !so_oe)
    else $error("serial output driven in receive direction");
  chk_frame_ignored: assert property (!frame_input_enable && $changed(frame_control_in) |=> $stable(so_oe) [*5])
    else $error("frame input acted while disabled");
  cov_frame_hiz: cover property ((frame_input_enable && frame_function_sel && frame_control_in) [*6]);
  cov_so_shift: cover property ($changed(so) && so_oe);
  cov_edge_drive: cover property (edge_seen && so_oe);
endmodule

// ### dv/ssp_tb_top.sv
// Purpose: Self-checking bench joining master and slave ends
// Assumes: One core clock for both ends
// Notes: Fixed settings table first, then random modes and bursts
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, a, b); end end
module ssp_tb_top;
  import ssp_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, tx_ready, tx_underrun, rx_valid, burst_done;
  logic gate = 1'b0;
  logic pol = 1'b0;
  logic pha = 1'b0;
  logic order = 1'b0;
  logic fen = 1'b0;
  logic fmode = 1'b0;
  logic bmode = 1'b0;
  logic txv = 1'b0;
  logic [15:0] blen = 16'h0001;
  logic [7:0] txd = 8'h00;
  logic [7:0] rx_data;
  logic [7:0] rx_q[$];
  integer seed = 7;
  int n_errors = 0;
  int total_checks = 0;
  int n_under = 0;
  int cyc = 0;
  // Settings {gate, frame, fmode, fen, order, phase, polarity}
  localparam logic [6:0] TBL [11] = '{7'h40, 7'h41, 7'h42, 7'h43, 7'h47, 7'h44,
    7'h78, 7'h48, 7'h68, 7'h00, 7'h60};
  ssp_if link();
  ssp_dev u_ssp_dev (.core_clk(core_clk), .nrst(nrst), .link(link.dev),
    .port_clock_gate_bit(gate), .clock_polarity_sel(pol), .clock_phase_sel(pha),
    .frame_input_enable(fen), .frame_function_sel(fmode), .bit_order_sel(order),
    .tx_enable(1'b1), .rx_enable(1'b1), .burst_mode(bmode), .burst_len(blen),
    .tx_data(txd), .tx_valid(txv), .tx_ready(tx_ready), .tx_underrun(tx_underrun),
    .rx_data(rx_data), .rx_valid(rx_valid), .burst_done(burst_done));
  ssp_mst u_ssp_mst (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link.mst));
  ssp_assertions u_ssp_assertions (.core_clk(core_clk), .nrst(nrst), .sck(link.sck),
    .si(link.si), .frame_control_in(link.frame_control_in), .so(link.so),
    .so_oe(link.so_oe), .frame_input_enable(fen), .frame_function_sel(fmode));
  // Core clock and run limit
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      n_errors++;
      stop_test();
    end
  end
  // Collect received bytes
  always @(posedge core_clk)
    if (rx_valid === 1'b1)
      rx_q.push_back(rx_data);
  // Count underrun pulses of the device's transmit reload
  always @(posedge core_clk)
    if (tx_underrun === 1'b1)
      n_under++;
  task automatic stop_test();
    if (n_errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int i = 0; i < 8; i++)
      rev8[i] = v[7 - i];
  endfunction
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Sample pready at each rising edge; data taken at that same edge
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // One framed exchange in the given settings
  task automatic xfer(input logic [6:0] c, input logic bm, input logic [15:0] bl);
    logic [7:0] mb, db;
    logic drv, rcv;
    mb = 8'($random(seed));
    db = 8'($random(seed));
    drv = c[6] && !(c[3] && (c[4] ? c[5] : !c[5]));
    rcv = c[6] && !(c[3] && !c[4] && c[5]);
    @(posedge core_clk);
    gate <= 1'b0;
    apb(1'b1, REG_CTRL, {28'h0, c[5], c[1], c[0], 1'b0});
    repeat (8) @(posedge core_clk);
    {fmode, fen, order, pha, pol} <= c[4:0];
    bmode <= bm;
    blen <= bl;
    repeat (8) @(posedge core_clk);
    gate <= c[6];
    if (drv)
    begin
      @(posedge core_clk);
      txd <= db;
      txv <= 1'b1;
      do @(posedge core_clk); while (tx_ready !== 1'b1);
      txv <= 1'b0;
    end
    rx_q.delete();
    n_under = 0;
    apb(1'b1, REG_NBITS, 32'h8);
    apb(1'b1, REG_TXD, {24'h0, mb});
    apb(1'b1, REG_CTRL, {28'h0, c[5], c[1], c[0], 1'b1});
    rd = 32'h0;
    while (rd[STAT_DONE] !== 1'b1) apb(1'b0, REG_STAT, 32'h0);
    repeat (12) @(posedge core_clk);
    apb(1'b0, REG_RXD, 32'h0);
    if (drv && !bm) `CHK(rd[7:0], c[2] ? rev8(db) : db)
    if (bm)
    begin
      `CHK(burst_done, (bl <= 16'h0008))
      `CHK(rx_q.size(), 1)
    end
    else if (rcv)
    begin
      `CHK(rx_q.size(), 1)
      if (rx_q.size() > 0) `CHK(rx_q[0], c[2] ? rev8(mb) : mb)
    end
    else `CHK(rx_q.size(), 0)
    `CHK(n_under, (drv && !bm && !c[1]) ? 1 : 0)
    apb(1'b1, REG_STAT, 32'h2);
  endtask
  // Main sequence
  initial
  begin
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
    foreach (TBL[i]) xfer(TBL[i], 1'b0, 16'h0);
    repeat (12) xfer({1'b1, 6'($random(seed))}, 1'b0, 16'h0);
    xfer(7'h40, 1'b1, 16'h0001);
    xfer(7'h41, 1'b1, 16'h0008);
    xfer(7'h42, 1'b1, 16'hFFFF);
    xfer(7'h43, 1'b1, 16'(($random(seed) & 7) + 1));
    stop_test();
  end
endmodule
